// file: verilog/data_map_access.sv
// Data-space decoder, pointer addressing and access stall control
`timescale 1ns/1ps
`include "data_map_regs.svh"
module data_map_access
  import data_map_pkg::*;
#(
  parameter logic [1:0] VARIANT = 2'h3
)
(
  input  wire logic        ref_clk_i,
  input  wire logic        resetn_i,
  input  wire logic        req_i,
  input  wire logic        data_space_write_i,
  input  wire logic [2:0]  mode_i,
  input  wire logic [1:0]  ptr_sel_i,
  input  wire logic [15:0] direct_addr_i,
  input  wire logic [5:0]  disp_i,
  input  wire logic [15:0] ptr_x_i,
  input  wire logic [15:0] ptr_y_i,
  input  wire logic [15:0] ptr_z_i,
  input  wire logic        nv_read_i,
  input  wire logic        nv_write_arm_i,
  input  wire logic        nv_write_strobe_i,
  input  wire logic [1:0]  nv_mode_i,
  input  wire logic [9:0]  nv_addr_i,
  input  wire logic [13:0] pc_next_i,
  output logic [15:0]      addr_o,
  output logic [4:0]       sel_o,
  output logic             data_space_load_o,
  output logic             data_space_write_o,
  output logic             ptr_we_o,
  output logic [1:0]       ptr_wsel_o,
  output logic [15:0]      ptr_wdata_o,
  output logic             stall_o,
  output logic             nv_write_arm_o,
  output logic             nv_write_strobe_o,
  output logic             nv_busy_o,
  output logic             nv_done_o,
  output logic             nv_read_o,
  output logic [9:0]       nv_addr_o,
  output logic [13:0]      prog_word_addr_o
);
  //------------------------------------------------------------
  // Variant decoding
  //------------------------------------------------------------
  function automatic logic [15:0] sram_last(input logic [1:0] v);
    case (v)
      2'h0:    sram_last = `SRAM_LAST_V0;
      2'h1:    sram_last = `SRAM_LAST_V1;
      2'h2:    sram_last = `SRAM_LAST_V2;
      default: sram_last = `SRAM_LAST_V3;
    endcase
  endfunction : sram_last

  function automatic logic [9:0] nv_last(input logic [1:0] v);
    case (v)
      2'h0:    nv_last = `NV_LAST_V0;
      2'h1:    nv_last = `NV_LAST_V1;
      2'h2:    nv_last = `NV_LAST_V2;
      default: nv_last = `NV_LAST_V3;
    endcase
  endfunction : nv_last

  function automatic logic [13:0] pc_mask(input logic [1:0] v);
    case (v)
      2'h0:    pc_mask = 14'h07FF;
      2'h1:    pc_mask = 14'h0FFF;
      2'h2:    pc_mask = 14'h1FFF;
      default: pc_mask = 14'h3FFF;
    endcase
  endfunction : pc_mask

  // One-hot region select from a data address
  function automatic logic [4:0] decode(input logic [15:0] a, input logic [1:0] v);
    if (a <= `REGFILE_LAST)
      decode = 5'h01;
    else if (a <= `STD_IO_LAST)
      decode = 5'h02;
    else if (a <= `EXT_IO_LAST)
      decode = 5'h04;
    else if (a <= sram_last(v))
      decode = 5'h08;
    else
      decode = 5'h10;
  endfunction : decode

  //------------------------------------------------------------
  // Pin-level nonvolatile control synchronisers
  //------------------------------------------------------------
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [2:0] sync_prev;
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      sync1     <= 3'h0;
      sync2     <= 3'h0;
      sync_prev <= 3'h0;
    end else begin
      sync1     <= {nv_read_i, nv_write_strobe_i, nv_write_arm_i};
      sync2     <= sync1;
      sync_prev <= sync2;
    end
  end

  logic arm_set;
  logic strobe_set;
  logic rd_set;
  assign arm_set    = sync2[0] && !sync_prev[0];
  assign strobe_set = sync2[1] && !sync_prev[1];
  assign rd_set     = sync2[2] && !sync_prev[2];

  //------------------------------------------------------------
  // Write engine
  //------------------------------------------------------------
  logic nv_armed;
  logic nv_busy;
  logic nv_start;
  logic nv_done;
  nv_write_timer u_timer (
    .ref_clk_i    (ref_clk_i),
    .resetn_i     (resetn_i),
    .arm_set_i    (arm_set),
    .strobe_set_i (strobe_set),
    .mode_i       (nv_mode_i),
    .armed_o      (nv_armed),
    .busy_o       (nv_busy),
    .start_o      (nv_start),
    .done_o       (nv_done)
  );

  //------------------------------------------------------------
  // Address generation
  //------------------------------------------------------------
  logic [15:0] base;
  logic [15:0] eff_addr;
  logic [15:0] upd_ptr;
  logic        upd;
  always_comb begin
    case (ptr_sel_i)
      PTR_X:   base = ptr_x_i;
      PTR_Y:   base = ptr_y_i;
      default: base = ptr_z_i;
    endcase
    eff_addr = base;
    upd_ptr  = base;
    upd      = 1'b0;
    case (mode_i)
      MODE_DIRECT:  eff_addr = direct_addr_i;
      MODE_INDIRECT: eff_addr = base;
      MODE_DISP: begin
        eff_addr = (ptr_sel_i == PTR_X) ? ptr_y_i : base;
        eff_addr = eff_addr + {10'h000, disp_i};
      end
      MODE_PREDEC: begin
        upd_ptr  = base - 16'h0001;
        eff_addr = upd_ptr;
        upd      = 1'b1;
      end
      MODE_POSTINC: begin
        eff_addr = base;
        upd_ptr  = base + 16'h0001;
        upd      = 1'b1;
      end
      MODE_PORT:
        eff_addr = {10'h000, direct_addr_i[5:0]} + `STD_IO_OFFSET;
      default: eff_addr = direct_addr_i;
    endcase
  end

  //------------------------------------------------------------
  // Access sequencer
  //------------------------------------------------------------
  acc_state_e  state;
  acc_state_e  next_state;
  logic [2:0]  cnt;
  logic [2:0]  next_cnt;
  logic [15:0] next_addr;
  logic [4:0]  next_sel;
  logic        next_ld;
  logic        next_st;
  logic        next_pwe;
  logic [1:0]  next_pwsel;
  logic [15:0] next_pwdata;
  logic        next_stall;
  logic        next_nvrd;
  logic [9:0]  next_nvaddr;
  always_comb begin
    next_state  = state;
    next_cnt    = cnt;
    next_addr   = addr_o;
    next_sel    = 5'h00;
    next_ld     = 1'b0;
    next_st     = 1'b0;
    next_pwe    = 1'b0;
    next_pwsel  = ptr_wsel_o;
    next_pwdata = ptr_wdata_o;
    next_stall  = 1'b0;
    next_nvrd   = 1'b0;
    next_nvaddr = nv_addr_o;
    case (state)
      ST_IDLE: begin
        if (rd_set && !nv_busy) begin
          next_nvrd   = 1'b1;
          next_nvaddr = nv_addr_i & nv_last(VARIANT);
          next_cnt    = `NV_READ_STALL;
          next_stall  = 1'b1;
          next_state  = ST_STALL;
        end else if (nv_start) begin
          next_cnt    = `NV_WRITE_STALL;
          next_stall  = 1'b1;
          next_state  = ST_STALL;
        end else if (req_i) begin
          next_addr  = eff_addr;
          next_sel   = decode(eff_addr, VARIANT);
          next_ld    = !data_space_write_i;
          next_st    = data_space_write_i;
          next_pwe   = upd;
          next_pwsel = ptr_sel_i;
          next_pwdata = upd_ptr;
          if (next_sel == 5'h08) begin
            next_stall = 1'b1;
            next_state = ST_SRAM;
          end
        end
      end
      ST_SRAM: begin
        next_sel   = sel_o;
        next_ld    = data_space_load_o;
        next_st    = data_space_write_o;
        next_state = ST_IDLE;
      end
      ST_STALL: begin
        if (cnt <= 3'h1) begin
          next_state = ST_IDLE;
        end else begin
          next_stall = 1'b1;
        end
        next_cnt = cnt - 3'h1;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // Registered outputs
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      state              <= ST_IDLE;
      cnt                <= 3'h0;
      addr_o             <= 16'h0000;
      sel_o              <= 5'h00;
      data_space_load_o  <= 1'b0;
      data_space_write_o <= 1'b0;
      ptr_we_o           <= 1'b0;
      ptr_wsel_o         <= 2'h0;
      ptr_wdata_o        <= 16'h0000;
      stall_o            <= 1'b0;
      nv_read_o          <= 1'b0;
      nv_addr_o          <= 10'h000;
      prog_word_addr_o   <= 14'h0000;
      nv_write_arm_o     <= 1'b0;
      nv_write_strobe_o  <= nv_busy;
      nv_busy_o          <= nv_busy;
      nv_done_o          <= nv_done;
    end else begin
      state              <= next_state;
      cnt                <= next_cnt;
      addr_o             <= next_addr;
      sel_o              <= next_sel;
      data_space_load_o  <= next_ld;
      data_space_write_o <= next_st;
      ptr_we_o           <= next_pwe;
      ptr_wsel_o         <= next_pwsel;
      ptr_wdata_o        <= next_pwdata;
      stall_o            <= next_stall;
      nv_read_o          <= next_nvrd;
      nv_addr_o          <= next_nvaddr;
      prog_word_addr_o   <= pc_next_i & pc_mask(VARIANT);
      nv_write_arm_o     <= nv_armed;
      nv_write_strobe_o  <= nv_busy;
      nv_busy_o          <= nv_busy;
      nv_done_o          <= nv_done;
    end
  end
endmodule : data_map_access

// file: verilog/data_map_regs.svh
// Constants for the data-space map and nonvolatile access timing
`ifndef DATA_MAP_REGS_SVH
`define DATA_MAP_REGS_SVH
`define REGFILE_LAST      16'h001F
`define STD_IO_FIRST      16'h0020
`define STD_IO_LAST       16'h005F
`define EXT_IO_FIRST      16'h0060
`define EXT_IO_LAST       16'h00FF
`define SRAM_FIRST        16'h0100
`define SRAM_LAST_V0      16'h02FF
`define SRAM_LAST_V1      16'h04FF
`define SRAM_LAST_V2      16'h04FF
`define SRAM_LAST_V3      16'h08FF
`define PC_WIDTH_V0       4'hB
`define PC_WIDTH_V1       4'hC
`define PC_WIDTH_V2       4'hD
`define PC_WIDTH_V3       4'hE
`define NV_LAST_V0        10'h0FF
`define NV_LAST_V1        10'h1FF
`define NV_LAST_V2        10'h1FF
`define NV_LAST_V3        10'h3FF
`define STD_IO_OFFSET     16'h0020
`define DISP_MAX          6'h3F
`define ARM_CYCLES        3'h4
`define NV_READ_STALL     3'h4
`define NV_WRITE_STALL    3'h2
`define SRAM_CYCLES       2'h2
`define CLK_PERIOD_NS     8
`define NV_ATOMIC_US      3400
`define NV_SPLIT_US       1800
`define NV_ATOMIC_CYCLES  ((`NV_ATOMIC_US * 1000) / `CLK_PERIOD_NS)
`define NV_SPLIT_CYCLES   ((`NV_SPLIT_US * 1000) / `CLK_PERIOD_NS)
`endif

// file: verilog/data_map_pkg.sv
// Types shared by the data-space map block
package data_map_pkg;
  typedef enum logic [2:0] {
    REGION_REGFILE = 3'b000,
    REGION_STD_IO  = 3'b001,
    REGION_EXT_IO  = 3'b010,
    REGION_SRAM    = 3'b011,
    REGION_NONE    = 3'b100
  } region_e;
  typedef enum logic [2:0] {
    MODE_DIRECT   = 3'b000,
    MODE_INDIRECT = 3'b001,
    MODE_DISP     = 3'b010,
    MODE_PREDEC   = 3'b011,
    MODE_POSTINC  = 3'b100,
    MODE_PORT     = 3'b101
  } addr_mode_e;
  typedef enum logic [1:0] {
    PTR_X = 2'b00,
    PTR_Y = 2'b01,
    PTR_Z = 2'b10
  } ptr_sel_e;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SRAM  = 2'b01,
    ST_STALL = 2'b10
  } acc_state_e;
  typedef enum logic [1:0] {
    NVM_ATOMIC = 2'b00,
    NVM_ERASE  = 2'b01,
    NVM_WRITE  = 2'b10,
    NVM_RSVD   = 2'b11
  } nv_mode_e;
endpackage : data_map_pkg

// file: verilog/nv_write_timer.sv
// Self-timed nonvolatile write engine with arm window
`timescale 1ns/1ps
`include "data_map_regs.svh"
module nv_write_timer
  import data_map_pkg::*;
(
  input  wire logic       ref_clk_i,
  input  wire logic       resetn_i,
  input  wire logic       arm_set_i,
  input  wire logic       strobe_set_i,
  input  wire logic [1:0] mode_i,
  output logic            armed_o,
  output logic            busy_o,
  output logic            start_o,
  output logic            done_o
);
  logic [2:0]  arm_cnt;
  logic [2:0]  next_arm_cnt;
  logic [19:0] wr_cnt;
  logic [19:0] next_wr_cnt;
  logic        busy;
  logic        next_busy;
  logic        start;
  logic        next_start;
  logic        done;
  logic        next_done;
  logic        go;

  // A strobe counts only inside the arm window and not while busy
  assign go = strobe_set_i && (arm_cnt != 3'h0) && !busy && (mode_i != NVM_RSVD);

  // Arm window and write duration
  always_comb begin
    next_arm_cnt = arm_cnt;
    next_wr_cnt  = wr_cnt;
    next_busy    = busy;
    next_start   = 1'b0;
    next_done    = 1'b0;
    if (arm_set_i) begin
      next_arm_cnt = `ARM_CYCLES;
    end else if (arm_cnt != 3'h0) begin
      next_arm_cnt = arm_cnt - 3'h1;
    end
    if (go) begin
      next_busy    = 1'b1;
      next_start   = 1'b1;
      next_arm_cnt = 3'h0;
      next_wr_cnt  = (mode_i == NVM_ATOMIC) ? 20'(`NV_ATOMIC_CYCLES) : 20'(`NV_SPLIT_CYCLES);
    end else if (busy) begin
      if (wr_cnt <= 20'h00001) begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end else begin
        next_wr_cnt = wr_cnt - 20'h00001;
      end
    end
  end

  // Reset clears the arm window and the start pulse; a running write finishes
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      arm_cnt <= 3'h0;
      start   <= 1'b0;
      // A running write keeps counting; an idle engine comes up cleared
      if (busy) begin
        done   <= next_done;
        busy   <= next_busy;
        wr_cnt <= next_wr_cnt;
      end else begin
        done   <= 1'b0;
        busy   <= 1'b0;
        wr_cnt <= 20'h00000;
      end
    end else begin
      arm_cnt <= next_arm_cnt;
      wr_cnt  <= next_wr_cnt;
      busy    <= next_busy;
      start   <= next_start;
      done    <= next_done;
    end
  end

  assign armed_o = arm_cnt != 3'h0;
  assign busy_o  = busy;
  assign start_o = start;
  assign done_o  = done;
endmodule : nv_write_timer

// file: verif/data_map_access_assertions.sv
// Checker for the data-space map ports
`timescale 1ns/1ps
`include "data_map_regs.svh"
module data_map_access_assertions #(
  parameter logic [1:0] VARIANT = 2'h3
)
(
  input wire logic        ref_clk_i,
  input wire logic        resetn_i,
  input wire logic [15:0] addr_o,
  input wire logic [4:0]  sel_o,
  input wire logic        stall_o,
  input wire logic        nv_write_arm_o,
  input wire logic        nv_busy_o,
  input wire logic [13:0] pc_next_i,
  input wire logic [13:0] prog_word_addr_o
);
  localparam logic [15:0] SRAM_END = (VARIANT == 2'h0) ? `SRAM_LAST_V0 :
                                     (VARIANT == 2'h3) ? `SRAM_LAST_V3 : `SRAM_LAST_V1;
  localparam int          PC_W     = int'(VARIANT) + `PC_WIDTH_V0;
  localparam logic [13:0] PC_MASK  = 14'((32'h1 << PC_W) - 32'h1);

  // ----------------------------------------
  // Clocking and sequences
  // ----------------------------------------
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!resetn_i);

  // Two-cycle SRAM select, stall in the first cycle only
  sequence sram_hold;
    (stall_o && sel_o[3]) ##1 (sel_o[3] && !stall_o) ##1 (!sel_o[3] || stall_o);
  endsequence
  // Arm window closes by itself
  sequence arm_closes;
    ##4 !nv_write_arm_o;
  endsequence

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  one_hot_sel_a: assert property (sel_o == 5'h00 || $onehot(sel_o))
    else $error("region select not one-hot");
  regfile_dec_a: assert property (sel_o[0] |-> addr_o <= `REGFILE_LAST)
    else $error("register file select out of range");
  std_io_dec_a: assert property (sel_o[1] |-> addr_o inside {[16'h0020:16'h005F]})
    else $error("standard io select out of range");
  ext_io_dec_a: assert property (sel_o[2] |-> addr_o inside {[16'h0060:16'h00FF]})
    else $error("extended io select out of range");
  sram_dec_a: assert property (sel_o[3] |-> addr_o >= 16'h0100 && addr_o <= SRAM_END)
    else $error("sram select out of range");
  unimpl_dec_a: assert property (sel_o[4] |-> addr_o > SRAM_END)
    else $error("unimplemented select inside map");
  sram_timing_a: assert property ($rose(sel_o[3]) |-> sram_hold)
    else $error("sram access not two cycles");
  arm_expiry_a: assert property ($rose(nv_write_arm_o) |-> arm_closes)
    else $error("arm window longer than four cycles");
  write_armed_a: assert property ($rose(nv_busy_o) |-> $past(nv_write_arm_o))
    else $error("write started without arm");
  pc_width_a: assert property ($past(resetn_i) |-> prog_word_addr_o == ($past(pc_next_i) & PC_MASK))
    else $error("program word address too wide");
endmodule : data_map_access_assertions

bind data_map_access data_map_access_assertions #(.VARIANT(VARIANT)) data_map_access_assertions_i (
  .ref_clk_i        (ref_clk_i),
  .resetn_i         (resetn_i),
  .addr_o           (addr_o),
  .sel_o            (sel_o),
  .stall_o          (stall_o),
  .nv_write_arm_o   (nv_write_arm_o),
  .nv_busy_o        (nv_busy_o),
  .pc_next_i        (pc_next_i),
  .prog_word_addr_o (prog_word_addr_o)
);

// file: verif/core_ptr_model.sv
// Core-side model holding the three pointer pairs
`timescale 1ns/1ps
module core_ptr_model
  import data_map_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        resetn_i,
  input  wire logic        ptr_we_i,
  input  wire logic [1:0]  ptr_wsel_i,
  input  wire logic [15:0] ptr_wdata_i,
  output logic [15:0]      ptr_x_o,
  output logic [15:0]      ptr_y_o,
  output logic [15:0]      ptr_z_o
);
  // Pointer pairs take the updated address written back by the block
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      ptr_x_o <= 16'h0200;
      ptr_y_o <= 16'h0300;
      ptr_z_o <= 16'h0400;
    end else if (ptr_we_i) begin
      case (ptr_wsel_i)
        2'h0: ptr_x_o <= ptr_wdata_i;
        2'h1: ptr_y_o <= ptr_wdata_i;
        default: ptr_z_o <= ptr_wdata_i;
      endcase
    end
  end
endmodule : core_ptr_model

// file: verif/tb_data_map_access.sv
// Self-checking bench for the data-space map block
`timescale 1ns/1ps
module tb_data_map_access;
  import data_map_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic ref_clk_i = 0, resetn_i = 0, req_i = 0, wr = 0, nv_rd = 0, arm = 0, stb = 0;
  logic [2:0]  mode_i = 0;
  logic [1:0]  psel = 0, nv_mode = 0, wsel;
  logic [15:0] daddr = 0, addr_o, px, py, pz, wdata;
  logic [5:0]  disp = 0;
  logic [9:0]  nv_addr = 0, nv_addr_o;
  logic [13:0] pc = 14'h2ABC, prog_o;
  logic [4:0]  sel_o, c_sel;
  logic        ld_o, st_o, we, stall_o, arm_o, strobe_o, busy_o, rd_o, c_stall, done_o;
  logic [15:0] c_addr;
  logic [1:0]  c_dir;
  int          fails = 0, samples_checked = 0, held;
  localparam logic [15:0] DEC_ADDR [9] = '{16'h0000, 16'h001F, 16'h0020, 16'h005F, 16'h0060,
                                          16'h00FF, 16'h0100, 16'h08FF, 16'h0900};
  localparam logic [4:0]  DEC_SEL [9]  = '{5'h01, 5'h01, 5'h02, 5'h02, 5'h04, 5'h04, 5'h08,
                                          5'h08, 5'h10};

  data_map_access #(.VARIANT(2'h3)) data_map_access_i (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .req_i(req_i), .data_space_write_i(wr),
    .mode_i(mode_i), .ptr_sel_i(psel), .direct_addr_i(daddr), .disp_i(disp),
    .ptr_x_i(px), .ptr_y_i(py), .ptr_z_i(pz), .nv_read_i(nv_rd), .nv_write_arm_i(arm),
    .nv_write_strobe_i(stb), .nv_mode_i(nv_mode), .nv_addr_i(nv_addr), .pc_next_i(pc),
    .addr_o(addr_o), .sel_o(sel_o), .data_space_load_o(ld_o), .data_space_write_o(st_o),
    .ptr_we_o(we), .ptr_wsel_o(wsel), .ptr_wdata_o(wdata), .stall_o(stall_o),
    .nv_write_arm_o(arm_o), .nv_write_strobe_o(strobe_o), .nv_busy_o(busy_o),
    .nv_done_o(done_o), .nv_read_o(rd_o), .nv_addr_o(nv_addr_o), .prog_word_addr_o(prog_o));
  core_ptr_model core_ptr_model_i (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .ptr_we_i(we), .ptr_wsel_i(wsel),
    .ptr_wdata_i(wdata), .ptr_x_o(px), .ptr_y_o(py), .ptr_z_o(pz));

  initial forever #4 ref_clk_i = ~ref_clk_i;

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task give_verdict;
    if (fails == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // One data access; captures the answer and counts select cycles
  task automatic acc(input logic [2:0] m, input logic [1:0] p, input logic [15:0] a,
                     input logic [5:0] d, input logic w);
    @(negedge ref_clk_i);
    req_i = 1; mode_i = m; psel = p; daddr = a; disp = d; wr = w;
    @(negedge ref_clk_i);
    req_i = 0;
    c_addr = addr_o; c_sel = sel_o; c_stall = stall_o; c_dir = {ld_o, st_o};
    held = 0;
    while (sel_o !== 5'h00) begin
      held++;
      if (held > 4) begin
        fails++;
        give_verdict();
      end
      @(negedge ref_clk_i);
    end
    @(negedge ref_clk_i);
  endtask : acc

  // Arm and strobe pins with a given mode; counts busy, stall and arm cycles
  task automatic nv_seq(input logic [1:0] m, input logic a, input logic s,
                        output int bn, output int sn, output int an);
    bn = 0; sn = 0; an = 0;
    @(negedge ref_clk_i);
    nv_mode = m; arm = a;
    @(negedge ref_clk_i);
    stb = s;
    repeat (12) begin
      @(negedge ref_clk_i);
      bn += int'(busy_o); sn += int'(stall_o); an += int'(arm_o);
    end
    arm = 0; stb = 0;
    repeat (3) @(negedge ref_clk_i);
  endtask : nv_seq

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_decode;
    for (int i = 0; i < 9; i++) begin
      acc(MODE_DIRECT, 2'h0, DEC_ADDR[i], 6'h00, i[0]);
      chk(16'(c_sel), 16'(DEC_SEL[i]));
      chk(c_addr, DEC_ADDR[i]);
      chk(16'(held), DEC_SEL[i][3] ? 16'h0002 : 16'h0001);
      chk(16'(c_stall), 16'(DEC_SEL[i][3]));
      if (i < 8) chk(16'(c_dir), i[0] ? 16'h0001 : 16'h0002);
    end
  endtask : t_decode

  task automatic t_pointer;
    acc(MODE_POSTINC, 2'h0, 16'h0000, 6'h00, 1'b0);
    chk(c_addr, 16'h0200);
    chk(px, 16'h0201);
    acc(MODE_PREDEC, 2'h1, 16'h0000, 6'h00, 1'b1);
    chk(c_addr, 16'h02FF);
    chk(py, 16'h02FF);
    acc(MODE_DISP, 2'h2, 16'h0000, 6'h3F, 1'b0);
    chk(c_addr, 16'h043F);
    chk(pz, 16'h0400);
    acc(MODE_INDIRECT, 2'h0, 16'h0000, 6'h00, 1'b0);
    chk(c_addr, 16'h0201);
    acc(MODE_PORT, 2'h0, 16'h00FF, 6'h00, 1'b0);
    chk(c_addr, 16'h005F);
    chk(16'(c_sel), 16'h0002);
  endtask : t_pointer

  task automatic t_nv_read;
    int st = 0;
    int pl = 0;
    logic [9:0] na = 10'h000;
    @(negedge ref_clk_i);
    nv_addr = 10'h2A5; nv_rd = 1;
    repeat (12) begin
      @(negedge ref_clk_i);
      st += int'(stall_o);
      if (rd_o === 1'b1) begin
        pl++;
        na = nv_addr_o;
      end
    end
    nv_rd = 0;
    chk(16'(st), 16'h0004);
    chk(16'(pl), 16'h0001);
    chk(16'(na), 16'h02A5);
  endtask : t_nv_read

  task automatic t_nv_write;
    int bn, sn, an;
    nv_seq(2'h2, 1'b0, 1'b1, bn, sn, an);
    chk(16'(bn), 16'h0000);
    nv_seq(2'h2, 1'b1, 1'b0, bn, sn, an);
    chk(16'(an), 16'h0004);
    nv_seq(2'h3, 1'b1, 1'b1, bn, sn, an);
    chk(16'(bn), 16'h0000);
    nv_seq(2'h2, 1'b1, 1'b1, bn, sn, an);
    chk(16'(bn != 0), 16'h0001);
    chk(16'(sn), 16'h0002);
    resetn_i = 0;
    repeat (3) @(negedge ref_clk_i);
    chk(16'(busy_o), 16'h0001);
    chk(16'(done_o), 16'h0000);
    resetn_i = 1;
    @(negedge ref_clk_i);
    chk(16'(busy_o), 16'h0001);
    chk(16'(strobe_o), 16'h0001);
  endtask : t_nv_write

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(negedge ref_clk_i);
    resetn_i = 1;
    repeat (2) @(negedge ref_clk_i);
    chk(16'(prog_o), 16'h2ABC);
    t_decode();
    t_pointer();
    t_nv_read();
    t_nv_write();
    give_verdict();
  end
endmodule : tb_data_map_access
